// *** src/ubt_map.svh ***
`ifndef UBT_MAP_SVH
`define UBT_MAP_SVH
// register addresses (byte address on the plain register port)
`define UBT_ADDR_MODE 4'h0
`define UBT_ADDR_DIV 4'h1
`define UBT_ADDR_PRESC 4'h2
`define UBT_ADDR_TXDATA 4'h3
`define UBT_ADDR_TXSTAT 4'h4
`define UBT_ADDR_RXDATA 4'h5
`define UBT_ADDR_RXERR 4'h6
// mode register fields
`define UBT_MODE_POWER 7
`define UBT_MODE_TXEN 6
`define UBT_MODE_RXEN 5
`define UBT_MODE_PAR_HI 4
`define UBT_MODE_PAR_LO 3
`define UBT_MODE_CHAR8 2
`define UBT_MODE_STOP2 1
`define UBT_MODE_MERGE 0
// transmit status fields
`define UBT_TXST_FULL 1
`define UBT_TXST_BUSY 0
// receive error status fields
`define UBT_ERR_PAR 2
`define UBT_ERR_FRAME 1
`define UBT_ERR_OVR 0
// reset values
`define UBT_MODE_RST 8'h01
`define UBT_DIV_RST 8'hFF
`define UBT_PRESC_RST 8'h00
`define UBT_RXDATA_RST 8'hFF
`define UBT_DIV_MIN 8'h08
// parity encodings
`define UBT_PAR_NONE 2'h0
`define UBT_PAR_ZERO 2'h1
`define UBT_PAR_ODD 2'h2
`define UBT_PAR_EVEN 2'h3
`endif

// *** src/ubt_pkg.sv ***
package ubt_pkg;
	// register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ubt_bus_s;
	// receive error set
	typedef struct packed {
		logic par;
		logic frame;
		logic ovr;
	} ubt_err_s;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ubt_tx_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ubt_rx_e;
endpackage

// *** src/ubt_uart.sv ***
`include "ubt_map.svh"
// Notes on behaviour
// - holding register refills once shifter starts
// - bit 1 of status: holding full
// - bit 0 of status: shifter busy
// - flags go 10, 01, 11 when streaming
// - receive sampling needs power then enable
// - falling edge, wait divisor, recheck low
// - stop bit: done pulse, copy unless overrun
// - parity error waits for frame end
// - receiver checks only one stop bit
// - parity, framing, overrun flags raise error
// - reading error status clears all flags
// - mode bit 0 merges errors into done
// - two equal samples pass new level
// - tx done at end of last stop
// - bit rate is base over twice divisor
module ubt_uart #(
	parameter int DIV_W = 8 // divisor width
) (
	input wire logic core_clk_i, // system clock, 10 MHz
	input wire logic nrst_i, // async reset, active low
	input wire ubt_pkg::ubt_bus_s bus_i, // register port request
	output logic [7:0] rdata_o, // read data, cycle after strobe
	input wire logic serial_in_pin_i, // receive line
	output logic serial_out_pin_o, // transmit line
	output logic tx_done_irq_o, // one-cycle transmit done
	output logic rx_done_irq_o, // one-cycle receive done
	output logic rx_error_irq_o // one-cycle receive error
);
	// configuration registers
	logic [7:0] serial_mode_reg; // power, enables, format
	logic [DIV_W-1:0] baud_divisor_reg; // divisor k
	logic [7:0] base_clock_select_reg; // prescaler ratio minus one
	logic [7:0] presc_reg; // prescaler counter
	logic base_en; // base clock enable pulse
	logic power_on; // unit powered
	logic tx_on; // transmitter enabled
	logic rx_on; // receiver enabled
	logic [1:0] par_mode; // parity selection
	logic char8; // 8-bit characters
	logic wr_tx; // host write to holding register
	logic rd_err; // host read of error status
	logic rd_data; // host read of receive data

	assign power_on = serial_mode_reg[`UBT_MODE_POWER];
	assign tx_on = power_on & serial_mode_reg[`UBT_MODE_TXEN];
	assign rx_on = power_on & serial_mode_reg[`UBT_MODE_RXEN];
	assign par_mode = serial_mode_reg[`UBT_MODE_PAR_HI:`UBT_MODE_PAR_LO];
	assign char8 = serial_mode_reg[`UBT_MODE_CHAR8];
	assign wr_tx = bus_i.wr && bus_i.addr == `UBT_ADDR_TXDATA;
	assign rd_err = bus_i.rd && bus_i.addr == `UBT_ADDR_RXERR;
	assign rd_data = bus_i.rd && bus_i.addr == `UBT_ADDR_RXDATA;

	// configuration writes
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			serial_mode_reg <= `UBT_MODE_RST;
			baud_divisor_reg <= DIV_W'(`UBT_DIV_RST);
			base_clock_select_reg <= `UBT_PRESC_RST;
		end else if (bus_i.wr) begin
			unique case (bus_i.addr)
				`UBT_ADDR_MODE: serial_mode_reg <= bus_i.wdata;
				// values below the minimum are held at it
				`UBT_ADDR_DIV: baud_divisor_reg <= (bus_i.wdata < `UBT_DIV_MIN) ?
					DIV_W'(`UBT_DIV_MIN) : DIV_W'(bus_i.wdata);
				`UBT_ADDR_PRESC: base_clock_select_reg <= bus_i.wdata;
				default: ;
			endcase
		end
	end

	// prescaler: base clock stops while unpowered
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			presc_reg <= 8'h00;
		end else if (!power_on || presc_reg == base_clock_select_reg) begin
			presc_reg <= 8'h00;
		end else begin
			presc_reg <= presc_reg + 8'h01;
		end
	end
	assign base_en = power_on && presc_reg == base_clock_select_reg;

	// ---------------- transmitter ----------------
	ubt_pkg::ubt_tx_e tx_state; // transmit sequencer
	logic [7:0] tx_holding_reg; // holding register
	logic tx_holding_full; // holding register occupied
	logic [7:0] tx_shifter; // transmit shifter
	logic [DIV_W:0] tx_cnt; // bit period counter, 2k per bit
	logic [2:0] tx_bit; // data bit index
	logic tx_stop2nd; // second stop bit in progress
	logic tx_par; // running parity of sent data
	logic tx_tick; // end of one bit period
	logic tx_shifter_busy; // shifter holds a frame
	logic tx_load; // move holding into shifter

	assign tx_shifter_busy = tx_state != ubt_pkg::TX_IDLE;
	assign tx_tick = base_en && tx_cnt == {baud_divisor_reg, 1'b0} - (DIV_W+1)'(1);
	assign tx_load = tx_on && !tx_shifter_busy && tx_holding_full;

	// holding register; set beats the load clear only by ordering, writes overwrite even when full=1
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_holding_reg <= 8'h00;
			tx_holding_full <= 1'b0;
		end else if (!tx_on) begin
			tx_holding_full <= 1'b0;
		end else if (wr_tx) begin
			tx_holding_reg <= bus_i.wdata;
			tx_holding_full <= 1'b1;
		end else if (tx_load) begin
			tx_holding_full <= 1'b0;
		end
	end

	// bit period counter, restarted at every frame start
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_cnt <= '0;
		end else if (!tx_on || tx_load) begin
			tx_cnt <= '0;
		end else if (tx_tick) begin
			tx_cnt <= '0;
		end else if (base_en) begin
			tx_cnt <= tx_cnt + (DIV_W+1)'(1);
		end
	end

	// frame sequencer
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_state <= ubt_pkg::TX_IDLE;
			tx_shifter <= 8'h00;
			tx_bit <= 3'h0;
			tx_stop2nd <= 1'b0;
			tx_par <= 1'b0;
			serial_out_pin_o <= 1'b1;
			tx_done_irq_o <= 1'b0;
		end else begin
			tx_done_irq_o <= 1'b0;
			if (!tx_on) begin
				tx_state <= ubt_pkg::TX_IDLE;
				serial_out_pin_o <= 1'b1;
			end else if (tx_load) begin
				tx_shifter <= tx_holding_reg;
				tx_state <= ubt_pkg::TX_START;
				tx_bit <= 3'h0;
				tx_par <= 1'b0;
				serial_out_pin_o <= 1'b0;
			end else if (tx_tick) begin
				unique case (tx_state)
					ubt_pkg::TX_START, ubt_pkg::TX_DATA: begin
						if (tx_state == ubt_pkg::TX_DATA && tx_bit == (char8 ? 3'h7 : 3'h6)) begin
							tx_state <= (par_mode == `UBT_PAR_NONE) ? ubt_pkg::TX_STOP : ubt_pkg::TX_PAR;
							serial_out_pin_o <= (par_mode == `UBT_PAR_NONE) ? 1'b1 :
								(par_mode == `UBT_PAR_ODD) ? ~tx_par :
								(par_mode == `UBT_PAR_EVEN) ? tx_par : 1'b0;
							tx_stop2nd <= 1'b0;
						end else begin
							if (tx_state == ubt_pkg::TX_DATA) begin
								tx_bit <= tx_bit + 3'h1;
							end
							tx_state <= ubt_pkg::TX_DATA;
							serial_out_pin_o <= tx_shifter[0];
							tx_par <= tx_par ^ tx_shifter[0];
							tx_shifter <= {1'b0, tx_shifter[7:1]};
						end
					end
					ubt_pkg::TX_PAR: begin
						tx_state <= ubt_pkg::TX_STOP;
						serial_out_pin_o <= 1'b1;
					end
					ubt_pkg::TX_STOP: begin
						if (serial_mode_reg[`UBT_MODE_STOP2] && !tx_stop2nd) begin
							tx_stop2nd <= 1'b1;
						end else begin
							tx_state <= ubt_pkg::TX_IDLE;
							tx_done_irq_o <= 1'b1;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// ---------------- receiver ----------------
	logic [1:0] rx_samp; // last two base-clock samples
	logic rx_filt; // filtered line level
	logic rx_filt_d; // previous filtered level for edge
	ubt_pkg::ubt_rx_e rx_state; // receive sequencer
	logic [DIV_W:0] rx_cnt; // receive baud counter
	logic [7:0] rx_shifter; // receive shifter
	logic [2:0] rx_bit; // data bit index
	logic rx_par; // running parity incl. parity bit
	logic rx_unread; // holding register not yet read
	logic [7:0] rx_holding_reg; // receive holding register
	ubt_pkg::ubt_err_s rx_error_status; // sticky error flags
	logic rx_mid; // sample point reached
	logic [DIV_W:0] rx_limit; // count for next sample point

	// the first sample point is k counts in, later ones 2k apart
	assign rx_limit = (rx_state == ubt_pkg::RX_START) ? {1'b0, baud_divisor_reg} :
		{baud_divisor_reg, 1'b0};
	assign rx_mid = base_en && rx_cnt == rx_limit - (DIV_W+1)'(1);

	// noise filter: level moves only when two samples agree
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_samp <= 2'h3;
			rx_filt <= 1'b1;
			rx_filt_d <= 1'b1;
		end else if (base_en) begin
			rx_samp <= {rx_samp[0], serial_in_pin_i};
			if (rx_samp[1] == rx_samp[0]) begin
				rx_filt <= rx_samp[0];
			end
			rx_filt_d <= rx_filt;
		end
	end

	// receive counter and sequencer
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_state <= ubt_pkg::RX_IDLE;
			rx_cnt <= '0;
			rx_shifter <= 8'h00;
			rx_bit <= 3'h0;
			rx_par <= 1'b0;
		end else if (!rx_on) begin
			rx_state <= ubt_pkg::RX_IDLE;
			rx_cnt <= '0;
		end else if (rx_state == ubt_pkg::RX_IDLE) begin
			if (base_en && rx_filt_d && !rx_filt) begin
				rx_state <= ubt_pkg::RX_START;
				rx_cnt <= '0;
			end
		end else if (rx_mid) begin
			rx_cnt <= '0;
			unique case (rx_state)
				ubt_pkg::RX_START: begin
					rx_state <= rx_filt ? ubt_pkg::RX_IDLE : ubt_pkg::RX_DATA;
					rx_bit <= 3'h0;
					rx_par <= 1'b0;
				end
				ubt_pkg::RX_DATA: begin
					rx_shifter <= char8 ? {rx_filt, rx_shifter[7:1]} : {1'b0, rx_filt, rx_shifter[6:1]};
					rx_par <= rx_par ^ rx_filt;
					rx_bit <= rx_bit + 3'h1;
					if (rx_bit == (char8 ? 3'h7 : 3'h6)) begin
						rx_state <= (par_mode == `UBT_PAR_NONE) ? ubt_pkg::RX_STOP : ubt_pkg::RX_PAR;
					end
				end
				ubt_pkg::RX_PAR: begin
					rx_par <= rx_par ^ rx_filt;
					rx_state <= ubt_pkg::RX_STOP;
				end
				ubt_pkg::RX_STOP: rx_state <= ubt_pkg::RX_IDLE;
				default: ;
			endcase
		end else if (base_en) begin
			rx_cnt <= rx_cnt + (DIV_W+1)'(1);
		end
	end

	// frame completion: errors, holding register, interrupts
	logic rx_end; // stop bit sampled
	ubt_pkg::ubt_err_s rx_new; // errors of this frame
	assign rx_end = rx_on && rx_mid && rx_state == ubt_pkg::RX_STOP;
	always_comb begin
		rx_new.par = (par_mode == `UBT_PAR_ODD) ? !rx_par :
			(par_mode == `UBT_PAR_EVEN) ? rx_par : 1'b0;
		rx_new.frame = !rx_filt;
		rx_new.ovr = rx_unread;
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_holding_reg <= `UBT_RXDATA_RST;
			rx_unread <= 1'b0;
			rx_error_status <= '0;
			rx_done_irq_o <= 1'b0;
			rx_error_irq_o <= 1'b0;
		end else begin
			rx_done_irq_o <= 1'b0;
			rx_error_irq_o <= 1'b0;
			if (rx_end) begin
				if (!rx_unread) begin
					rx_holding_reg <= rx_shifter;
				end
				rx_unread <= 1'b1;
				// new errors win over a same-cycle clearing read
				rx_error_status <= (rd_err ? '0 : rx_error_status) | rx_new;
				if (|rx_new && !serial_mode_reg[`UBT_MODE_MERGE]) begin
					rx_error_irq_o <= 1'b1;
				end else begin
					rx_done_irq_o <= 1'b1;
				end
			end else begin
				if (rd_data) begin
					rx_unread <= 1'b0;
				end
				if (rd_err) begin
					rx_error_status <= '0;
				end
			end
		end
	end

	// read data, valid the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
		end else if (bus_i.rd) begin
			unique case (bus_i.addr)
				`UBT_ADDR_MODE: rdata_o <= serial_mode_reg;
				`UBT_ADDR_DIV: rdata_o <= 8'(baud_divisor_reg);
				`UBT_ADDR_PRESC: rdata_o <= base_clock_select_reg;
				`UBT_ADDR_TXSTAT: rdata_o <= {6'h00, tx_holding_full, tx_shifter_busy};
				`UBT_ADDR_RXDATA: rdata_o <= rx_holding_reg;
				`UBT_ADDR_RXERR: rdata_o <= {5'h00, rx_error_status};
				default: rdata_o <= 8'h00;
			endcase
		end
	end

	AST_FULL_CLEARS_ON_LOAD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		tx_load && !wr_tx |=> !tx_holding_full && tx_shifter_busy)
		else $error("load did not move holding to shifter");
	AST_START_BIT_LOW: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		tx_load |=> !serial_out_pin_o)
		else $error("frame start not low");
	AST_DONE_IDLE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		tx_done_irq_o |-> !tx_shifter_busy && serial_out_pin_o)
		else $error("tx done while busy");
	AST_WRITE_SETS_FULL: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		wr_tx && tx_on |=> tx_holding_full)
		else $error("write did not set full");
	AST_RX_OFF_IDLE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		!rx_on |=> rx_state == ubt_pkg::RX_IDLE)
		else $error("receiver active while off");
	AST_ERR_CLEAR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		rd_err && !rx_end |=> rx_error_status == '0)
		else $error("error status not cleared by read");
	AST_OVR_KEEPS: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		rx_end && rx_unread |=> rx_holding_reg == $past(rx_holding_reg) && rx_error_status.ovr)
		else $error("overrun overwrote holding");
	AST_IRQ_ROUTE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		rx_end && |rx_new && !serial_mode_reg[`UBT_MODE_MERGE] |=> rx_error_irq_o && !rx_done_irq_o)
		else $error("error routing wrong");
	AST_FILTER: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		base_en && rx_samp[1] != rx_samp[0] |=> rx_filt == $past(rx_filt))
		else $error("filter passed unequal samples");
endmodule

// *** tb/ubt_node.sv ***
// remote serial node: sends 8-bit even-parity frames, captures sent bytes
module ubt_node #(
	parameter int BIT = 16 // clocks per bit: 2k base enables, k 8, prescale 0
) (
	input wire logic clk_i, // bench clock
	input wire logic line_i, // node receive line
	output logic line_o, // node transmit line
	output logic got_o, // one-cycle pulse, byte captured
	output logic [7:0] byte_o // captured byte
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle line is high, as the serial format demands
	initial begin
		line_o = 1'b1;
		got_o = 1'b0;
		byte_o = 8'h00;
	end
	// start, data lsb first, parity, one stop; faults only on request
	task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
		logic [10:0] f;
		f = {~bad_stop, ^d ^ bad_par, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			line_o <= f[i];
			repeat (BIT) @(posedge clk_i);
		end
		// a faulty stop leaves the line low: release it and let an edge pass,
		// so a following frame never drives the line twice in one step
		if (!f[10]) begin
			line_o <= 1'b1;
			@(posedge clk_i);
		end
	endtask
	// one-clock low spike, too short for the input filter
	task automatic glitch();
		line_o <= 1'b0;
		@(posedge clk_i);
		line_o <= 1'b1;
	endtask
	// capture at mid-bit; parity and stops skipped
	always begin
		@(negedge line_i);
		repeat (BIT / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk_i);
			byte_o[i] <= line_i;
		end
		got_o <= 1'b1;
		@(posedge clk_i);
		got_o <= 1'b0;
		repeat (2 * BIT) @(posedge clk_i);
	end
endmodule

// *** tb/test_uart_buffered_tx_rx_errors.sv ***
`include "ubt_map.svh"
module test_uart_buffered_tx_rx_errors;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk; // 10 MHz
	logic nrst; // active low
	ubt_pkg::ubt_bus_s bus; // register request
	logic [7:0] rdata; // read data
	logic ser_rx; // node to block
	logic ser_tx; // block to node
	logic tx_done; // transmit done pulse
	logic rx_done; // receive done pulse
	logic rx_err; // receive error pulse
	logic got; // node captured a byte
	logic [7:0] got_byte; // node's byte
	logic [15:0] rd_q[$]; // read notes {mask, value}
	logic [7:0] ser_q[$]; // bytes the node should see
	logic rd_pend = 1'b0; // read answer due this edge
	logic [7:0] seed = 8'h28; // lfsr state
	logic [7:0] v; // last read value
	logic [7:0] rst_v [8] = '{8'h01, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00}; // reset values
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	int n_tx = 0;
	int n_rx = 0;
	int n_err = 0;
	int w;
	int low_len = 0; // current low run on the transmit line, clocks
	int low_max = 0; // longest low run seen on the transmit line
	ubt_uart ubt_uart_i (.core_clk_i(core_clk), .nrst_i(nrst), .bus_i(bus), .rdata_o(rdata),
		.serial_in_pin_i(ser_rx), .serial_out_pin_o(ser_tx), .tx_done_irq_o(tx_done),
		.rx_done_irq_o(rx_done), .rx_error_irq_o(rx_err));
	ubt_node ubt_node_i (.clk_i(core_clk), .line_i(ser_tx), .line_o(ser_rx), .got_o(got), .byte_o(got_byte));
	// free-running clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input logic [7:0] got_v, input logic [7:0] exp_v);
		tests_run++;
		if (got_v !== exp_v) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
		end
	endtask
	// counts and lengths; logic arguments keep an unknown from passing
	task automatic check_n(input logic [15:0] got_n, input logic [15:0] exp_n);
		tests_run++;
		if (got_n !== exp_n) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got_n, exp_n);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// answers land one cycle after the strobe is taken; masked bits ignored
	always @(posedge core_clk) begin
		rd_pend <= bus.rd;
		if (rd_pend && rd_q.size() > 0) begin
			check(rdata & rd_q[0][15:8], rd_q[0][7:0]);
			void'(rd_q.pop_front());
		end
	end
	// bytes seen on the line, oldest note first
	always @(posedge core_clk) begin
		if (got === 1'b1 && ser_q.size() > 0) begin
			check(got_byte, ser_q[0]);
			void'(ser_q.pop_front());
		end
	end
	// pulse counters and hang limit
	always @(posedge core_clk) begin
		cyc++;
		n_tx += int'(tx_done === 1'b1);
		n_rx += int'(rx_done === 1'b1);
		n_err += int'(rx_err === 1'b1);
		// break length is judged from the longest low run
		low_len = (ser_tx === 1'b0) ? low_len + 1 : 0;
		if (low_len > low_max) begin
			low_max = low_len;
		end
		if (cyc == 8000) begin
			fails++;
			conclude();
		end
	end
	// each bus task enters and leaves on a rising edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus <= '0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		rd_q.push_back({m, x});
		@(posedge core_clk);
		bus <= '0;
		@(posedge core_clk);
		v = rdata;
	endtask
	// bounded wait on a pulse count
	task automatic wait_for(input int want, input logic tx_side);
		for (int i = 0; i < 600 && (tx_side ? n_tx : n_rx + n_err) < want; i++) @(posedge core_clk);
	endtask
	// one frame in, then errors read before data
	task automatic rx_frame(input logic [7:0] d, input logic bp, input logic bs, input logic [7:0] e);
		int want;
		want = n_rx + n_err + 1;
		ubt_node_i.send(d, bp, bs);
		wait_for(want, 1'b0);
		rd(`UBT_ADDR_RXERR, 8'hFF, e);
		rd(`UBT_ADDR_RXDATA, 8'hFF, d);
	endtask
	initial begin
		nrst = 1'b0;
		bus = '0;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		// reset values; tx data is write-only, 7 is unmapped
		for (int a = 0; a < 8; a++) rd(4'(a), (a == 3) ? 8'h00 : 8'hFF, rst_v[a]);
		$display("test reset done");
		// traffic while powered down is ignored
		ubt_node_i.send(8'h5A, 1'b0, 1'b0);
		wr(`UBT_ADDR_DIV, 8'h05);
		rd(`UBT_ADDR_DIV, 8'hFF, 8'h08);
		wr(`UBT_ADDR_MODE, 8'h80);
		wr(`UBT_ADDR_MODE, 8'hFC);
		ubt_node_i.glitch();
		repeat (200) @(posedge core_clk);
		check_n(16'(n_rx + n_err), 16'h0000);
		$display("test enable done");
		// back-to-back transmit, next byte written while shifting
		wr(`UBT_ADDR_TXDATA, 8'hA5);
		ser_q.push_back(8'hA5);
		repeat (4) @(posedge core_clk);
		rd(`UBT_ADDR_TXSTAT, 8'h03, 8'h01);
		wr(`UBT_ADDR_TXDATA, 8'h3C);
		ser_q.push_back(8'h3C);
		rd(`UBT_ADDR_TXSTAT, 8'h03, 8'h03);
		for (int i = 0; i < 400 && v[1] !== 1'b0; i++) rd(`UBT_ADDR_TXSTAT, 8'hFC, 8'h00);
		seed = lfsr(seed);
		wr(`UBT_ADDR_TXDATA, seed);
		ser_q.push_back(seed);
		wait_for(3, 1'b1);
		rd(`UBT_ADDR_TXSTAT, 8'hFF, 8'h00);
		check_n(16'(n_tx), 16'h0003);
		// break field: zero byte, even parity, divisor k=13, so 10 low bits (start, 8 data, parity) of 2*13 clocks
		wr(`UBT_ADDR_DIV, 8'h0D);
		wr(`UBT_ADDR_TXDATA, 8'h00);
		ser_q.push_back(8'h00);
		wait_for(4, 1'b1);
		check_n(16'(low_max), 16'(13 * 2 * 10));
		wr(`UBT_ADDR_DIV, 8'h08);
		$display("test transmit done");
		// two stops configured, node sends one: framing error only for the bad stop
		wr(`UBT_ADDR_MODE, 8'hFE);
		seed = lfsr(seed);
		rx_frame(seed, 1'b0, 1'b0, 8'h00);
		rx_frame(8'hC3, 1'b1, 1'b0, 8'h04);
		check_n(16'(n_err), 16'h0001);
		rd(`UBT_ADDR_RXERR, 8'hFF, 8'h00);
		rx_frame(8'h96, 1'b0, 1'b1, 8'h02);
		// overrun: second frame lands on an unread one, old byte kept
		w = n_rx + n_err + 2;
		ubt_node_i.send(8'h11, 1'b0, 1'b0);
		ubt_node_i.send(8'h22, 1'b0, 1'b0);
		wait_for(w, 1'b0);
		rd(`UBT_ADDR_RXERR, 8'hFF, 8'h01);
		rd(`UBT_ADDR_RXDATA, 8'hFF, 8'h11);
		$display("test receive done");
		// merged routing: parity error comes through receive done
		wr(`UBT_ADDR_MODE, 8'hFF);
		rx_frame(8'h5A, 1'b1, 1'b0, 8'h04);
		check_n(16'(n_err), 16'h0003);
		check_n(16'(n_rx), 16'h0003);
		// two stop bits on transmit: byte still arrives and the frame gives one done pulse
		wr(`UBT_ADDR_TXDATA, 8'h69);
		ser_q.push_back(8'h69);
		wait_for(5, 1'b1);
		check_n(16'(n_tx), 16'h0005);
		$display("test merge done");
		conclude();
	end
endmodule
